// ---- design/smartcard_pkg.sv ----
package smartcard_pkg;

  localparam int ADDR_W = 3;
  localparam int ETU_W = 11;
  localparam int GT_W = 9;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_ETU_LOW = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_ETU_HIGH = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_GUARD_LOW = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_GUARD_HIGH = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 3'h5;
  localparam logic [ADDR_W-1:0] OFS_TX_DATA = 3'h6;
  localparam logic [ADDR_W-1:0] OFS_RX_DATA = 3'h7;

  // etu high register fields
  localparam int ETUH_COMP_BIT = 7;
  // control register fields
  localparam int CTL_UART_BIT = 0;
  localparam int CTL_INVERT_BIT = 1;
  localparam int CTL_MSB_FIRST_BIT = 2;
  localparam int CTL_T0_BIT = 3;
  localparam int CTL_BG_ENABLE_BIT = 4;
  // status register fields
  localparam int ST_TX_FULL_BIT = 0;
  localparam int ST_RX_FULL_BIT = 1;
  localparam int ST_PAR_ERR_BIT = 2;
  localparam int ST_TX_FAIL_BIT = 3;
  localparam int ST_BUSY_BIT = 4;
  localparam int ST_RETRY_BIT = 5;

  // reset values
  localparam logic [ETU_W-1:0] ETU_RESET = 11'h174;
  localparam logic [GT_W-1:0] GUARD_RESET = 9'h00C;
  localparam logic [GT_W-1:0] COUNT_PARKED = 9'h1FF;
  localparam logic [7:0] CONTROL_RESET = 8'h09;

  // character timing, in etu indices from the leading edge
  localparam logic [3:0] IDX_PARITY = 4'h9;
  localparam logic [3:0] IDX_GUARD = 4'hA;
  localparam logic [3:0] IDX_ERR_END = 4'hC;
  localparam logic [2:0] MAX_TRIES = 3'h5;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } regReq_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_TX,
    ST_RX,
    ST_ERRSIG
  } charState_t;

endpackage

// ---- design/etu_divider.sv ----
`timescale 1ns/1ps
module etu_divider #(
  parameter int W = 11
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic restart,
  input wire logic shorten,
  input wire logic [W-1:0] etuVal,
  output logic tick,
  output logic half
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  wire [W-1:0] limit = etuVal - {{(W-1){1'b0}}, shorten};
  wire atEnd = (cnt_r >= limit - {{(W-1){1'b0}}, 1'b1});

  // restart aligns the bit grid to the character's leading edge
  assign cnt_nxt = (restart || atEnd) ? '0 : cnt_r + {{(W-1){1'b0}}, 1'b1};
  assign tick = atEnd && !restart;
  assign half = (cnt_r == (limit >> 1)) && !restart;

  always_ff @(posedge mclk)
  begin
    if (rst)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end
endmodule

// ---- design/smartcard_char_timing.sv ----
// Summary of operation
// - shifter converts serial line and eight-bit byte
// - selectable bit order and inversion of values
// - parity generated on send, checked on receive
// - separate transmit and receive byte buffers
// - sent character stays in shifter for repeats
// - sequencer runs only in character mode
// - transmission wins over reception when both pending
// - eleven-bit divider gives one tick per etu
// - compensation shortens even bits by one clock
// - guard counter starts at one, counts to limit
// - guard register reads programmed value, not count
// - block guard clears on each received character
// - block guard reaching shadow permits, then stops
// - shadow loads on enable rising edge only
// - block guard programmable up to 511 etus
// - parity error drives line low 2 etus from 10.5
// - transmitter samples error, repeats, five tries max
`timescale 1ns/1ps
module smartcard_char_timing #(
  parameter int ETU_W = smartcard_pkg::ETU_W,
  parameter int GT_W = smartcard_pkg::GT_W
) (
  input wire logic mclk,
  input wire logic rst,
  input wire smartcard_pkg::regReq_t regReq,
  output logic [7:0] regRdata,
  input wire logic ioIn,
  output logic ioOut,
  output logic ioOe
);
  import smartcard_pkg::*;

  logic [ETU_W-1:0] etuVal_r;
  logic comp_r;
  logic [GT_W-1:0] guardVal_r;
  logic [7:0] control_r;
  logic [GT_W-1:0] bgShadow_r;
  logic [GT_W-1:0] gtCnt_r;
  logic [GT_W-1:0] bgCnt_r;
  logic [7:0] txBuf_r;
  logic [7:0] rxBuf_r;
  logic txFull_r;
  logic rxFull_r;
  logic parErr_r;
  logic txFail_r;
  logic retry_r;
  logic rxBad_r;
  logic [2:0] tries_r;
  logic [8:0] shift_r;
  logic [3:0] bitIdx_r;
  logic ioPrev_r;
  logic [7:0] regRdata_r;
  logic ioOut_r;
  logic ioOe_r;
  charState_t state_r;
  charState_t state_nxt;
  logic etuTick;
  logic etuHalf;

  // control decode
  wire uartMode = control_r[CTL_UART_BIT];
  wire invert = control_r[CTL_INVERT_BIT];
  wire msbFirst = control_r[CTL_MSB_FIRST_BIT];
  wire t0Mode = control_r[CTL_T0_BIT];
  wire bgEnable = control_r[CTL_BG_ENABLE_BIT];

  // register write and read decode
  wire wrEtuLow = regReq.wr && (regReq.addr == OFS_ETU_LOW);
  wire wrEtuHigh = regReq.wr && (regReq.addr == OFS_ETU_HIGH);
  wire wrGuardLow = regReq.wr && (regReq.addr == OFS_GUARD_LOW);
  wire wrGuardHigh = regReq.wr && (regReq.addr == OFS_GUARD_HIGH);
  wire wrControl = regReq.wr && (regReq.addr == OFS_CONTROL);
  wire wrStatus = regReq.wr && (regReq.addr == OFS_STATUS);
  wire wrTxData = regReq.wr && (regReq.addr == OFS_TX_DATA);
  wire rdRxData = regReq.rd && (regReq.addr == OFS_RX_DATA);
  wire bgRise = wrControl && regReq.wdata[CTL_BG_ENABLE_BIT] && !bgEnable;

  // bit order reversal, both directions
  logic [7:0] txRev;
  logic [7:0] rxRev;
  wire [8:0] rxWord = {invert ^ ioIn, shift_r[8:1]};
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_rev
      assign txRev[gi] = txBuf_r[7-gi];
      assign rxRev[gi] = rxWord[7-gi];
    end
  endgenerate
  wire [7:0] txOrdered = msbFirst ? txRev : txBuf_r;
  wire [7:0] rxOrdered = msbFirst ? rxRev : rxWord[7:0];
  wire txParity = ^txBuf_r;
  wire rxParityBad = ^rxWord;

  // spacing permits
  wire gtDone = (gtCnt_r >= guardVal_r);
  wire bgDone = !bgEnable || (bgCnt_r >= bgShadow_r);
  wire txPending = txFull_r || retry_r;
  wire txGo = uartMode && txPending && gtDone && bgDone;
  wire startEdge = uartMode && ioPrev_r && !ioIn;

  wire inIdle = (state_r == ST_IDLE);
  wire inTx = (state_r == ST_TX);
  wire inRx = (state_r == ST_RX);
  wire inErr = (state_r == ST_ERRSIG);
  wire startTx = inIdle && txGo;
  wire startRx = inIdle && !txGo && startEdge;

  // receive milestones
  wire rxHalf = inRx && etuHalf;
  wire rxStartLost = rxHalf && (bitIdx_r == 4'h0) && ioIn;
  wire rxSample = rxHalf && (bitIdx_r != 4'h0) && (bitIdx_r <= IDX_PARITY);
  wire rxLast = rxHalf && (bitIdx_r == IDX_PARITY);
  wire rxEnd = rxHalf && (bitIdx_r == IDX_GUARD);
  wire errSigGo = rxEnd && rxBad_r && t0Mode;
  wire errSigEnd = inErr && etuHalf && (bitIdx_r == IDX_ERR_END);

  // transmit milestones
  wire txTick = inTx && etuTick;
  wire txRotate = txTick && (bitIdx_r != 4'h0) && (bitIdx_r <= IDX_PARITY);
  wire txCheck = txTick && (bitIdx_r == IDX_GUARD);
  wire txErrSeen = txCheck && t0Mode && !ioIn;
  wire [8:0] shiftRot = {shift_r[0], shift_r[8:1]};
  wire [8:0] txLoad = {txParity, txOrdered};

  // compensation applies to even-numbered bits of the character
  wire shortBit = comp_r && !bitIdx_r[0] && !inIdle;

  etu_divider #(
    .W(ETU_W)
  ) u_etu (
    .mclk(mclk),
    .rst(rst),
    .restart(startTx || startRx),
    .shorten(shortBit),
    .etuVal(etuVal_r),
    .tick(etuTick),
    .half(etuHalf)
  );

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (startTx)
          state_nxt = ST_TX;
        else if (startRx)
          state_nxt = ST_RX;
      ST_TX:
        if (txCheck || !uartMode)
          state_nxt = ST_IDLE;
      ST_RX:
        if (errSigGo)
          state_nxt = ST_ERRSIG;
        else if (rxEnd || rxStartLost || !uartMode)
          state_nxt = ST_IDLE;
      ST_ERRSIG:
        if (errSigEnd || !uartMode)
          state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // next line drive; start bit is always a low level
  wire driveData = txTick && (bitIdx_r < IDX_PARITY);
  wire [8:0] nextShift = (bitIdx_r == 4'h0) ? shift_r : shiftRot;
  wire ioOe_nxt = startTx || errSigGo || (inTx && !(txTick && bitIdx_r == IDX_PARITY)
    && bitIdx_r <= IDX_PARITY) || (inErr && !errSigEnd);
  wire ioOut_nxt = driveData ? (invert ^ nextShift[0]) : (inTx && !startTx && ioOut_r);

  // register read mux; guard reads back the setting, never the count
  logic [7:0] status;
  assign status = {2'b00, retry_r, !inIdle, txFail_r, parErr_r, rxFull_r, txFull_r};
  wire [7:0] rdMux =
    (regReq.addr == OFS_ETU_LOW) ? etuVal_r[7:0] :
    (regReq.addr == OFS_ETU_HIGH) ? {comp_r, 4'h0, etuVal_r[ETU_W-1:8]} :
    (regReq.addr == OFS_GUARD_LOW) ? guardVal_r[7:0] :
    (regReq.addr == OFS_GUARD_HIGH) ? {7'h00, guardVal_r[GT_W-1]} :
    (regReq.addr == OFS_CONTROL) ? control_r :
    (regReq.addr == OFS_STATUS) ? status :
    (regReq.addr == OFS_TX_DATA) ? txBuf_r :
    rxBuf_r;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      regRdata_r <= 8'h00;
      ioOut_r <= 1'b0;
      ioOe_r <= 1'b0;
      ioPrev_r <= 1'b1;
      bitIdx_r <= 4'h0;
    end
    else
    begin
      state_r <= state_nxt;
      regRdata_r <= regReq.rd ? rdMux : 8'h00;
      ioOut_r <= ioOut_nxt;
      ioOe_r <= ioOe_nxt;
      ioPrev_r <= ioIn;
      if (startTx || startRx)
        bitIdx_r <= 4'h0;
      else if (etuTick && bitIdx_r != 4'hF)
        bitIdx_r <= bitIdx_r + 4'h1;
    end
  end

  // software registers
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      etuVal_r <= ETU_RESET;
      comp_r <= 1'b0;
      guardVal_r <= GUARD_RESET;
      control_r <= CONTROL_RESET;
      bgShadow_r <= GUARD_RESET;
      txBuf_r <= 8'h00;
    end
    else
    begin
      if (wrEtuLow)
        etuVal_r[7:0] <= regReq.wdata;
      if (wrEtuHigh)
      begin
        etuVal_r[ETU_W-1:8] <= regReq.wdata[ETU_W-9:0];
        comp_r <= regReq.wdata[ETUH_COMP_BIT];
      end
      if (wrGuardLow)
        guardVal_r[7:0] <= regReq.wdata;
      if (wrGuardHigh)
        guardVal_r[GT_W-1] <= regReq.wdata[0];
      if (wrControl)
        control_r <= regReq.wdata;
      // later guard writes leave the shadow alone
      if (bgRise)
        bgShadow_r <= guardVal_r;
      if (wrTxData)
        txBuf_r <= regReq.wdata;
    end
  end

  // shifter, buffers and flags
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      shift_r <= 9'h000;
      rxBuf_r <= 8'h00;
      txFull_r <= 1'b0;
      rxFull_r <= 1'b0;
      parErr_r <= 1'b0;
      txFail_r <= 1'b0;
      retry_r <= 1'b0;
      rxBad_r <= 1'b0;
      tries_r <= 3'h0;
    end
    else
    begin
      // a retry keeps the old shifter content instead of reloading
      if (startTx && !retry_r)
        shift_r <= txLoad;
      else if (txRotate)
        shift_r <= shiftRot;
      else if (rxSample)
        shift_r <= rxWord;
      if (startTx && !retry_r)
        tries_r <= 3'h1;
      else if (startTx)
        tries_r <= tries_r + 3'h1;
      // a byte written in the start cycle stays pending, not lost
      if (wrTxData)
        txFull_r <= 1'b1;
      else if (startTx && !retry_r)
        txFull_r <= 1'b0;
      if (wrTxData)
        retry_r <= 1'b0;
      else if (txErrSeen && tries_r < MAX_TRIES)
        retry_r <= 1'b1;
      else if (startTx)
        retry_r <= 1'b0;
      if (txErrSeen && tries_r >= MAX_TRIES)
        txFail_r <= 1'b1;
      else if (wrStatus && regReq.wdata[ST_TX_FAIL_BIT])
        txFail_r <= 1'b0;
      if (rxLast)
        rxBad_r <= rxParityBad;
      if (rxLast && rxParityBad)
        parErr_r <= 1'b1;
      else if (wrStatus && regReq.wdata[ST_PAR_ERR_BIT])
        parErr_r <= 1'b0;
      // in error-signal mode a bad character is not delivered
      if (rxLast && !(rxParityBad && t0Mode))
        rxBuf_r <= rxOrdered;
      if (rxLast && !(rxParityBad && t0Mode))
        rxFull_r <= 1'b1;
      else if (rdRxData)
        rxFull_r <= 1'b0;
    end
  end

  // guard and block guard counters
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      gtCnt_r <= COUNT_PARKED;
      bgCnt_r <= COUNT_PARKED;
    end
    else
    begin
      if (startTx)
        gtCnt_r <= {{(GT_W-1){1'b0}}, 1'b1};
      // first etu holds at one, so the limit is leading-edge spacing
      else if (etuTick && !gtDone && !(inTx && bitIdx_r == 4'h0))
        gtCnt_r <= gtCnt_r + {{(GT_W-1){1'b0}}, 1'b1};
      // terminal send parks the counter at its limit
      if (startTx)
        bgCnt_r <= bgShadow_r;
      else if (startRx && bgEnable)
        bgCnt_r <= '0;
      else if (etuTick && bgCnt_r < bgShadow_r)
        bgCnt_r <= bgCnt_r + {{(GT_W-1){1'b0}}, 1'b1};
    end
  end

  assign regRdata = regRdata_r;
  assign ioOut = ioOut_r;
  assign ioOe = ioOe_r;
endmodule

// ---- dv/smartcard_char_timing_monitor.sv ----
`timescale 1ns/1ps
module smartcard_char_timing_monitor
  import smartcard_pkg::*;
#(
  parameter int ETU_W = 11,
  parameter int GT_W = 9
) (
  input wire logic mclk,
  input wire logic rst,
  input wire smartcard_pkg::regReq_t regReq,
  input wire logic [7:0] regRdata,
  input wire logic ioIn,
  input wire logic ioOut,
  input wire logic ioOe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic [7:0] gLo_r, ctl_r, eLo_r, eHi_r;
  logic [15:0] oeCnt_r;
  wire [ETU_W-1:0] etuV = {eHi_r[ETU_W-9:0], eLo_r};
  wire [2:0] a = regReq.addr;
  // mirrors of written registers; etu must not change mid-character
  always_ff @(posedge mclk)
  begin
    oeCnt_r <= ioOe ? oeCnt_r + 16'h0001 : 16'h0000;
    if (rst)
    begin
      gLo_r <= GUARD_RESET[7:0];
      ctl_r <= CONTROL_RESET;
      {eHi_r, eLo_r} <= {5'h00, ETU_RESET};
    end
    else if (regReq.wr)
      case (a)
        OFS_ETU_LOW: eLo_r <= regReq.wdata;
        OFS_ETU_HIGH: eHi_r <= regReq.wdata;
        OFS_GUARD_LOW: gLo_r <= regReq.wdata;
        OFS_CONTROL: ctl_r <= regReq.wdata;
        default: ;
      endcase
  end
  property p_rd_idle; !$past(regReq.rd) |-> regRdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data out of slot");
  property p_guard_rd; regReq.rd && a == OFS_GUARD_LOW |=> regRdata == gLo_r; endproperty
  a_guard_rd: assert property (p_guard_rd) else $error("guard read wrong");
  property p_etu_rd; regReq.rd && a == OFS_ETU_LOW |=> regRdata == eLo_r; endproperty
  a_etu_rd: assert property (p_etu_rd) else $error("etu read wrong");
  property p_start; $rose(ioOe) |-> !ioOut; endproperty
  a_start: assert property (p_start) else $error("drive not low at start");
  property p_oe_min; $rose(ioOe) |-> ioOe [*8]; endproperty
  a_oe_min: assert property (p_oe_min) else $error("drive too short");
  property p_mode; !ctl_r[CTL_UART_BIT] && !ioOe |=> !ioOe; endproperty
  a_mode: assert property (p_mode) else $error("drive outside char mode");
  property p_bit_edge;
    ioOe && $past(ioOe) && ioOut != $past(ioOut) && !eHi_r[ETUH_COMP_BIT]
      |-> oeCnt_r % etuV == 0;
  endproperty
  a_bit_edge: assert property (p_bit_edge) else $error("bit edge off etu");
  property p_rx_hold;
    $fell(ioIn) && !ioOe && !$past(ioOe) && ctl_r[CTL_UART_BIT] |=> !ioOe [*4];
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("drive during receive");
  c_tx: cover property ($rose(ioOe));
  c_rx: cover property ($fell(ioIn) && !ioOe);
  c_gr: cover property (regReq.rd && a == OFS_GUARD_LOW);
endmodule

bind smartcard_char_timing smartcard_char_timing_monitor #(.ETU_W(ETU_W), .GT_W(GT_W))
  smartcard_char_timing_monitor_i (.mclk(mclk), .rst(rst), .regReq(regReq),
  .regRdata(regRdata), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe));

// ---- dv/card.sv ----
`timescale 1ns/1ps
module card #(
  parameter int E = 8
) (
  input wire logic mclk,
  input wire logic line,
  input wire logic nak,
  input wire logic conv,
  output logic low,
  output logic nakSeen,
  output logic [7:0] rxByte,
  output int rxCount
);
  logic busy = 1'b0;
  logic [9:0] sh;
  initial low = 1'b0;
  initial nakSeen = 1'b0;
  initial rxCount = 0;
  // own frames are ignored; error low only when told to
  always
  begin
    @(negedge line);
    if (!busy)
    begin
      repeat (E / 2) @(posedge mclk);
      for (int i = 0; i < 10; i++)
      begin
        sh[i] = line;
        repeat (E) @(posedge mclk);
      end
      for (int i = 0; i < 8; i++) rxByte[i] = conv ? !sh[8-i] : sh[i+1];
      rxCount++;
      if (nak)
      begin
        low <= 1'b1;
        repeat (E + E / 4) @(posedge mclk);
        low <= 1'b0;
      end
    end
  end
  task automatic send(input logic [7:0] b, input logic bad);
    logic [9:0] f;
    f[0] = 1'b0;
    for (int i = 0; i < 8; i++) f[i+1] = conv ? !b[7-i] : b[i];
    f[9] = (^b) ^ bad ^ conv;
    busy = 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      low <= !f[i];
      repeat (E) @(posedge mclk);
    end
    low <= 1'b0;
    repeat (E) @(posedge mclk);
    nakSeen = !line;
    repeat (2 * E) @(posedge mclk);
    busy = 1'b0;
  endtask
endmodule

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import smartcard_pkg::*;
  localparam int E = 8;
`define CHK(g, x) begin tests_run++; if ((g) !== (x)) begin err_count++; \
  $display("MISMATCH %0t got %0h exp %0h", $time, g, x); end end
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic nak = 1'b0;
  logic conv = 1'b0;
  regReq_t regReq = '0;
  logic [7:0] regRdata, rxByte, rv;
  logic ioOut, ioOe, cardLow, nakSeen;
  int err_count = 0;
  int tests_run = 0;
  int tmo = 0;
  int tRise, hiLen, t1, d1, c0, rxCount;
  // open-drain line, pull-up
  wire line = !(ioOe === 1'b1 && ioOut === 1'b0) && !cardLow;
  smartcard_char_timing smartcard_char_timing_i (.mclk(mclk), .rst(rst), .regReq(regReq),
    .regRdata(regRdata), .ioIn(line), .ioOut(ioOut), .ioOe(ioOe));
  card #(.E(E)) card_i (.mclk(mclk), .line(line), .nak(nak), .conv(conv), .low(cardLow),
    .nakSeen(nakSeen), .rxByte(rxByte), .rxCount(rxCount));
  always #20 mclk = ~mclk;
  always @(posedge mclk)
  begin
    tmo++;
    if (tmo == 20000)
    begin
      err_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    regReq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    regReq <= '0;
    @(posedge mclk);
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] x);
    regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    regReq <= '0;
    #1 rv = regRdata;
    @(posedge mclk);
    `CHK(rv & m, x)
  endtask
  // lead and length of the next driven frame
  task automatic txWait();
    while (ioOe !== 1'b1) @(posedge mclk);
    tRise = int'($time / 40);
    while (ioOe === 1'b1) @(posedge mclk);
    hiLen = int'($time / 40) - tRise;
  endtask
  task automatic tx(input logic [7:0] b);
    wr(OFS_TX_DATA, b);
    txWait();
  endtask
  initial
  begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rc(OFS_ETU_LOW, 8'hFF, ETU_RESET[7:0]);
    rc(OFS_ETU_HIGH, 8'h87, {5'h00, ETU_RESET[10:8]});
    rc(OFS_GUARD_LOW, 8'hFF, GUARD_RESET[7:0]);
    rc(OFS_CONTROL, 8'h1F, CONTROL_RESET);
    rc(OFS_STATUS, 8'hFF, 8'h00);
    wr(OFS_ETU_LOW, E[7:0]);
    wr(OFS_ETU_HIGH, 8'h00);
    $display("done reset");
    tx(8'hA5);
    t1 = tRise;
    tx(8'h3C);
    d1 = tRise - t1;
    `CHK(hiLen, 10 * E)
    `CHK((d1 >= 12 * E) && (d1 <= 12 * E + 1), 1'b1)
    wr(OFS_GUARD_LOW, 8'h14);
    tx(8'h0F);
    t1 = tRise;
    rc(OFS_GUARD_LOW, 8'hFF, 8'h14);
    tx(8'hF0);
    `CHK(tRise - t1 - d1, 8 * E)
    repeat (2 * E) @(posedge mclk);
    `CHK(rxByte, 8'hF0)
    wr(OFS_GUARD_LOW, 8'h0C);
    wr(OFS_ETU_HIGH, 8'h80);
    tx(8'h81);
    `CHK(10 * E - hiLen, 5)
    wr(OFS_ETU_HIGH, 8'h00);
    $display("done timing");
    wr(OFS_CONTROL, 8'h08);
    wr(OFS_TX_DATA, 8'h42);
    repeat (16 * E) @(posedge mclk);
    rc(OFS_STATUS, 8'h11, 8'h01);
    wr(OFS_CONTROL, 8'h09);
    txWait();
    repeat (2 * E) @(posedge mclk);
    `CHK(rxByte, 8'h42)
    conv <= 1'b1;
    wr(OFS_CONTROL, 8'h0F);
    tx(8'hB1);
    repeat (2 * E) @(posedge mclk);
    `CHK(rxByte, 8'hB1)
    card_i.send(8'h2D, 1'b0);
    rc(OFS_RX_DATA, 8'hFF, 8'h2D);
    conv <= 1'b0;
    wr(OFS_CONTROL, 8'h09);
    $display("done modes");
    card_i.send(8'h66, 1'b1);
    `CHK(nakSeen, 1'b1)
    rc(OFS_STATUS, 8'h06, 8'h04);
    wr(OFS_STATUS, 8'h04);
    card_i.send(8'h99, 1'b0);
    `CHK(nakSeen, 1'b0)
    rc(OFS_STATUS, 8'h06, 8'h02);
    rc(OFS_RX_DATA, 8'hFF, 8'h99);
    nak <= 1'b1;
    c0 = rxCount;
    tx(8'h5A);
    repeat (70 * E) @(posedge mclk);
    `CHK(rxCount - c0, 5)
    `CHK(rxByte, 8'h5A)
    rc(OFS_STATUS, 8'h08, 8'h08);
    nak <= 1'b0;
    wr(OFS_STATUS, 8'h08);
    $display("done errors");
    wr(OFS_GUARD_LOW, 8'h16);
    wr(OFS_CONTROL, 8'h19);
    wr(OFS_GUARD_LOW, 8'h0C);
    t1 = int'($time / 40);
    card_i.send(8'h33, 1'b0);
    tx(8'hCC);
    `CHK((tRise - t1 >= 21 * E) && (tRise - t1 <= 23 * E + 8), 1'b1)
    repeat (2 * E) @(posedge mclk);
    wr(OFS_CONTROL, 8'h09);
    $display("done block guard");
    give_verdict();
  end
endmodule
